// ==== common/pic_defs.vh ====
// Register map, field positions and reset values of the interrupt controller
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH
`define PIC_ADDR_W 12
`define PIC_OFF_REQ0 12'hfc0
`define PIC_OFF_ENH0 12'hfc1
`define PIC_OFF_ENL0 12'hfc2
`define PIC_OFF_REQ1 12'hfc3
`define PIC_OFF_ENH1 12'hfc4
`define PIC_OFF_ENL1 12'hfc5
`define PIC_OFF_REQ2 12'hfc6
`define PIC_OFF_ENH2 12'hfc7
`define PIC_OFF_ENL2 12'hfc8
`define PIC_OFF_EDGE 12'hfcd
`define PIC_OFF_SHARED 12'hfce
`define PIC_OFF_CTL 12'hfcf
`define PIC_OFF_VECTOR 12'hfc9
`define PIC_RST_BYTE 8'h00
`define PIC_REQ2_MASK 8'h0f
`define PIC_CTL_GIE 7
`define PIC_NSRC 24
`define PIC_IDX_W 5
`define PIC_LVL_OFF 2'h0
`endif

// ==== hdl/pic_prio_pick.v ====
// Priority picker: highest level first, lowest source index among equals
`timescale 1ns/1ps
`default_nettype none
module pic_prio_pick (
  input wire [23:0] pending,
  input wire [23:0] enHigh,
  input wire [23:0] enLow,
  output reg found,
  output reg [4:0] srcIdx,
  output reg [1:0] srcLevel
);
  integer i;
  reg [1:0] lvl;
  always @* begin
    found = 1'b0;
    srcIdx = 5'h00;
    srcLevel = 2'h0;
    lvl = 2'h0;
    for (i = 23; i >= 0; i = i - 1) begin
      lvl = {enHigh[i], enLow[i]};
      if (pending[i] && lvl != 2'h0 && lvl >= srcLevel) begin
        found = 1'b1;
        srcIdx = i[4:0];
        srcLevel = lvl;
      end
    end
  end
endmodule // pic_prio_pick
`default_nettype wire

// ==== hdl/pic_ctrl.v ====
// Prioritized interrupt controller with request, enable and control registers
// Functional notes
// - Global enable gates all forwarding
// - Enable-interrupts instruction sets global enable
// - Source request sets its pending bit
// - Enabled mode forwards pending enabled requests
// - Disabled mode never interrupts; software polls
// - Group two: port C bits 3..0
// - Enable pair: off, low, nominal, high
// - Enable bit x controls request bit x
// - Registers at fc0..fc9, fcd..fcf
`timescale 1ns/1ps
`include "pic_defs.vh"
`default_nettype none
module pic_ctrl (
  input wire mclk,
  input wire rst_n,
  input wire [11:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire [7:0] group0Source,
  input wire [7:0] group1Source,
  input wire [3:0] portcPinRequest,
  input wire enableInterruptsInstr,
  input wire irqAck,
  output reg irqReq,
  output reg [4:0] irqVector,
  output reg [1:0] irqLevel
);
  // ************************************************************
  // Registers
  // ************************************************************
  reg [23:0] pend_reg;
  reg [23:0] pend_next;
  reg [23:0] enh_reg;
  reg [23:0] enl_reg;
  reg [7:0] edge_reg;
  reg [7:0] shared_reg;
  reg [7:0] ctl_reg;
  reg [7:0] ctl_next;
  wire found;
  wire [4:0] pickIdx;
  wire [1:0] pickLvl;
  integer g;

  function [7:0] pic_group;
    input [23:0] v;
    input [1:0] grp;
    begin
      pic_group = v[8*grp +: 8];
    end
  endfunction

  wire [23:0] srcVec = {4'h0, portcPinRequest, group1Source, group0Source};

  // ************************************************************
  // Write decode
  // ************************************************************
  // Offset of one group's register, kept at 12 bits
  function [11:0] pic_off;
    input [11:0] base;
    input [1:0] grp;
    begin
      pic_off = base + ({10'h000, grp} << 1) + {10'h000, grp};
    end
  endfunction

  wire [2:0] hitReq;
  wire [2:0] hitEnh;
  wire [2:0] hitEnl;
  genvar gi;

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_dec
      localparam [1:0] GRP = gi;
      assign hitReq[gi] = regWr && (regAddr == pic_off(`PIC_OFF_REQ0, GRP));
      assign hitEnh[gi] = regWr && (regAddr == pic_off(`PIC_OFF_ENH0, GRP));
      assign hitEnl[gi] = regWr && (regAddr == pic_off(`PIC_OFF_ENL0, GRP));
    end
  endgenerate

  pic_prio_pick picker (
    .pending(pend_reg),
    .enHigh(enh_reg),
    .enLow(enl_reg),
    .found(found),
    .srcIdx(pickIdx),
    .srcLevel(pickLvl)
  );

  // ************************************************************
  // Pending and control next state
  // ************************************************************
  always @* begin
    pend_next = pend_reg;
    ctl_next = ctl_reg;
    if (regWr) begin
      for (g = 0; g < 3; g = g + 1) begin
        if (hitReq[g])
          pend_next[8*g +: 8] = regWdata;
      end
      if (regAddr == `PIC_OFF_CTL)
        ctl_next = regWdata;
    end
    // Acknowledged request leaves pending
    if (irqAck && irqReq)
      pend_next[irqVector] = 1'b0;
    pend_next = pend_next | srcVec;
    pend_next[23:20] = 4'h0;
    if (enableInterruptsInstr)
      ctl_next[`PIC_CTL_GIE] = 1'b1;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 24'h000000;
      enh_reg <= 24'h000000;
      enl_reg <= 24'h000000;
      edge_reg <= `PIC_RST_BYTE;
      shared_reg <= `PIC_RST_BYTE;
      ctl_reg <= `PIC_RST_BYTE;
    end else begin
      pend_reg <= pend_next;
      ctl_reg <= ctl_next;
      if (regWr) begin
        for (g = 0; g < 3; g = g + 1) begin
          if (hitEnh[g])
            enh_reg[8*g +: 8] <= regWdata;
          if (hitEnl[g])
            enl_reg[8*g +: 8] <= regWdata;
        end
        if (regAddr == `PIC_OFF_EDGE)
          edge_reg <= regWdata;
        if (regAddr == `PIC_OFF_SHARED)
          shared_reg <= regWdata;
      end
    end
  end

  // ************************************************************
  // Processor request
  // ************************************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq <= 1'b0;
      irqVector <= 5'h00;
      irqLevel <= 2'h0;
    end else begin
      irqReq <= ctl_next[`PIC_CTL_GIE] & found & ~(irqAck & irqReq);
      irqVector <= pickIdx;
      irqLevel <= pickLvl;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  // address decode
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `PIC_OFF_REQ0: regRdata <= pic_group(pend_reg, 2'h0);
        `PIC_OFF_ENH0: regRdata <= pic_group(enh_reg, 2'h0);
        `PIC_OFF_ENL0: regRdata <= pic_group(enl_reg, 2'h0);
        `PIC_OFF_REQ1: regRdata <= pic_group(pend_reg, 2'h1);
        `PIC_OFF_ENH1: regRdata <= pic_group(enh_reg, 2'h1);
        `PIC_OFF_ENL1: regRdata <= pic_group(enl_reg, 2'h1);
        `PIC_OFF_REQ2: regRdata <= pic_group(pend_reg, 2'h2);
        `PIC_OFF_ENH2: regRdata <= pic_group(enh_reg, 2'h2);
        `PIC_OFF_ENL2: regRdata <= pic_group(enl_reg, 2'h2);
        `PIC_OFF_VECTOR: regRdata <= {found, pickLvl, pickIdx};
        `PIC_OFF_EDGE: regRdata <= edge_reg;
        `PIC_OFF_SHARED: regRdata <= shared_reg;
        `PIC_OFF_CTL: regRdata <= ctl_reg;
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule // pic_ctrl
`default_nettype wire

// ==== verification/pic_ctrl_sva.sv ====
// Port checker for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_sva (
  input wire mclk,
  input wire rst_n,
  input wire [11:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata,
  input wire [7:0] group0Source,
  input wire [7:0] group1Source,
  input wire [3:0] portcPinRequest,
  input wire enableInterruptsInstr,
  input wire irqAck,
  input wire irqReq,
  input wire [4:0] irqVector,
  input wire [1:0] irqLevel
);
  reg gie_reg;
  wire gieNext;
  // Enable bit as it will stand after this edge
  assign gieNext = enableInterruptsInstr | ((regWr && regAddr == 12'hfcf) ? regWdata[7] : gie_reg);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) gie_reg <= 1'b0;
    else gie_reg <= gieNext;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_gate; !gieNext |=> !irqReq; endproperty
  a_gate: assert property (p_gate) else $error("request while disabled");
  property p_ei; enableInterruptsInstr ##[1:3] (regRd && regAddr == 12'hfcf) |=> regRdata[7]; endproperty
  a_ei: assert property (p_ei) else $error("enable bit not set");
  property p_pend; !gie_reg && portcPinRequest[0] ##6 (regRd && regAddr == 12'hfc6) |=> regRdata[0]; endproperty
  a_pend: assert property (p_pend) else $error("pending bit lost");
  property p_ack; irqAck |=> !irqReq; endproperty
  a_ack: assert property (p_ack) else $error("request held after ack");
  property p_res; regRd && regAddr == 12'hfc6 |=> regRdata[7:4] == 4'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_lvl; irqReq |-> irqLevel != 2'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("disabled source forwarded");
  property p_vec; irqReq |-> irqVector < 5'd20; endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  property p_gap; regRd && regAddr == 12'hfca |=> regRdata == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read not zero");
endmodule // pic_ctrl_sva
bind pic_ctrl pic_ctrl_sva pic_ctrl_sva_inst (.*);
`default_nettype wire

// ==== verification/pic_core_model.sv ====
// Processor core model that takes vectored interrupts
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
  input wire mclk,
  input wire rst_n,
  input wire irqReq,
  output logic irqAck
);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) irqAck <= 1'b0;
    else irqAck <= irqReq && !irqAck;
  end
endmodule // pic_core_model
`default_nettype wire

// ==== verification/tb_pic_ctrl.sv ====
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_pic_ctrl;
  logic mclk = 0, rst_n = 0, regWr = 0, regRd = 0, enableInterruptsInstr = 0, irqAck, irqReq, rdPend = 0;
  logic [11:0] regAddr = 0;
  logic [7:0] regWdata = 0, regRdata, group0Source = 0, group1Source = 0;
  logic [3:0] portcPinRequest = 0;
  logic [4:0] irqVector;
  logic [1:0] irqLevel;
  logic [31:0] seed = 44847;
  int err_total = 0, n_compared = 0;
  logic [7:0] q[$], vq[$];
  pic_ctrl pic_ctrl_inst (.*);
  pic_core_model pic_core_model_inst (.*);
  initial forever #5 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task chk(input logic [7:0] s, input logic [7:0] x, input string n);
    n_compared++;
    if (s !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    @(posedge mclk);
    regWr <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1;
    q.push_back(x);
    @(posedge mclk);
    regRd <= 0;
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rdPend) chk(regRdata, q.pop_front(), "read data");
    if (irqAck) chk({1'b0, irqLevel, irqVector}, vq.pop_front(), "vector and level");
    rdPend <= regRd;
  end
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    for (int a = 0; a < 16; a++) rd({8'hfc, a[3:0]}, 8'h00);
    $display("reset test done");
    wr(12'hfc2, 8'h04);
    wr(12'hfc4, 8'h02);
    wr(12'hfc5, 8'h02);
    wr(12'hfc7, 8'h01);
    @(posedge mclk);
    {group0Source, group1Source, portcPinRequest} <= {8'h04, 8'h02, 4'h1};
    @(posedge mclk);
    {group0Source, group1Source, portcPinRequest} <= 20'h0;
    rd(12'hfc0, 8'h04);
    rd(12'hfc3, 8'h02);
    rd(12'hfc6, 8'h01);
    vq = '{8'h69, 8'h50, 8'h22};
    @(posedge mclk);
    enableInterruptsInstr <= 1;
    @(posedge mclk);
    enableInterruptsInstr <= 0;
    rd(12'hfcf, 8'h80);
    for (int i = 0; i < 50 && vq.size() > 0; i++) @(posedge mclk);
    chk(8'(vq.size()), 8'h00, "vectors left");
    rd(12'hfc0, 8'h00);
    rd(12'hfc6, 8'h00);
    $display("priority test done");
    vq.push_back(8'h50);
    wr(12'hfc6, 8'hff);
    rd(12'hfc6, 8'h0f);
    seed = xs(seed);
    wr(12'hfcd, seed[7:0]);
    rd(12'hfcd, seed[7:0]);
    @(posedge mclk);
    chk(8'(vq.size()), 8'h00, "vectors left");
    $display("register test done");
    end_sim;
  end
endmodule // tb_pic_ctrl
`default_nettype wire
